//--- bit_shifter.sv
// Serial-in byte shift register with bit counter
`timescale 1ns/100ps
`default_nettype none
module bit_shifter
  import two_wire_slave_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Control
  input wire logic i_clear,
  input wire logic i_shift,
  input wire logic i_bit,
  // Result
  output logic [7:0] o_byte,
  output logic [3:0] o_count
);
  logic [7:0] byte_q;
  logic [3:0] count_q;

  always_ff @(posedge i_clk) begin
    if (i_reset || i_clear) begin
      byte_q <= 8'h00;
      count_q <= 4'h0;
    end else if (i_shift) begin
      byte_q <= {byte_q[6:0], i_bit};
      count_q <= count_q + 4'h1;
    end
  end

  assign o_byte = byte_q;
  assign o_count = count_q;
endmodule
`default_nettype wire

//--- pin_sync.sv
// Two-stage synchroniser for a pin from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import two_wire_slave_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pin and synchronised level
  input wire logic i_pin,
  output logic o_level
);
  logic meta_q;
  logic level_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
    end else begin
      meta_q <= i_pin;
      level_q <= meta_q;
    end
  end

  assign o_level = level_q;
endmodule
`default_nettype wire

//--- test_two_wire_slave_event_irq.sv
// Self-checking bench for the two-wire slave event block
`timescale 1ns/100ps
`default_nettype none
module test_two_wire_slave_event_irq
  import two_wire_slave_pkg::*;
;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  logic [ADDR_W-1:0] i_addr = 12'h0;
  logic [DATA_W-1:0] i_wdata = 32'h0;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [DATA_W-1:0] o_rdata, rv;
  logic o_scl_out, o_scl_oe_n, o_sda_out, o_sda_oe_n, o_irq, m_scl, m_sda, m_ack;
  wire logic i_scl = m_scl & (o_scl_oe_n | o_scl_out);
  wire logic i_sda = m_sda & (o_sda_oe_n | o_sda_out);
  int bad_count = 0;
  int n_compared = 0;
  logic [ADDR_W-1:0] offs [4] = '{OFS_EV_WRITE_CMD, OFS_EV_READ_CMD, OFS_SHORTCUTS,
    OFS_INT_ENABLE};
  int ie_bits [6] = '{IE_STOPPED, IE_ERROR, IE_RX_BEGUN, IE_TX_BEGUN, IE_WRITE_CMD,
    IE_READ_CMD};

  always #2 i_clk = ~i_clk;

  two_wire_slave_event_irq DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(i_scl), .i_sda(i_sda), .o_scl_out(o_scl_out),
    .o_scl_oe_n(o_scl_oe_n), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq));
  two_wire_master_model master (.i_scl(i_scl), .i_sda(i_sda), .o_scl(m_scl),
    .o_sda(m_sda), .o_ack(m_ack));

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk);
    i_wr <= 1'h0;
    #1;
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1 rv = o_rdata;
    chk($sformatf("reg %h", a), e, rv);
  endtask
  task automatic wait_oe();
    int k;
    for (k = 0; k < 400 && o_scl_oe_n !== 1'h0; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk("stretch", 32'h0, {31'h0, o_scl_oe_n});
    if (k == 400) report_and_stop();
  endtask

  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'h0;
    @(posedge i_clk);
    foreach (offs[i]) rc(offs[i], 32'h0);
    $display("reset values done");
    wr(OFS_SHORTCUTS, 32'hffff_ffff);
    rc(OFS_SHORTCUTS, 32'h3);
    wr(12'h204, 32'hffff_ffff);
    rc(12'h204, 32'h0);
    wr(OFS_INT_ENABLE, 32'hffff_ffff);
    rc(OFS_INT_ENABLE, IE_VALID);
    foreach (ie_bits[i]) begin
      wr(OFS_INT_ENABLE, 32'h1 << ie_bits[i]);
      rc(OFS_INT_ENABLE, 32'h1 << ie_bits[i]);
    end
    $display("register access done");
    wr(OFS_OWN_ADDR, 32'h2a);
    wr(OFS_ENABLE, 32'h1);
    wr(OFS_SHORTCUTS, 32'h0);
    wr(OFS_INT_ENABLE, 32'h1 << IE_WRITE_CMD);
    wr(OFS_TASK_RESUME, 32'h1);
    master.send(8'h54);
    chk("ack", 32'h1, {31'h0, m_ack});
    chk("sda out", 32'h0, {31'h0, o_sda_out});
    chk("irq", 32'h1, {31'h0, o_irq});
    rc(OFS_EV_RX_BEGUN, 32'h1);
    rc(OFS_EV_READ_CMD, 32'h0);
    wr(OFS_EV_WRITE_CMD, 32'h1);
    wr(OFS_EV_WRITE_CMD, 32'h0);
    @(posedge i_clk);
    #1 chk("irq", 32'h0, {31'h0, o_irq});
    rc(OFS_EV_WRITE_CMD, 32'h0);
    $display("write command done");
    master.send(8'h55);
    chk("irq", 32'h0, {31'h0, o_irq});
    rc(OFS_EV_READ_CMD, 32'h1);
    rc(OFS_EV_TX_BEGUN, 32'h1);
    rc(OFS_EV_READ_CMD, 32'h0);
    $display("read command done");
    for (int i = 0; i < 2; i++) begin
      wr(OFS_SHORTCUTS, 32'h1 << i);
      fork
        master.send({7'h2a, i[0]});
        begin
          wait_oe();
          wr(OFS_TASK_RESUME, 32'h1);
        end
      join
      @(posedge i_clk);
      chk("ack", 32'h1, {31'h0, m_ack});
      wr(OFS_SHORTCUTS, 32'h0);
    end
    $display("shortcuts done");
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- two_wire_master_model.sv
// Behavioural two-wire bus master for the slave event bench
`timescale 1ns/100ps
`default_nettype none
module two_wire_master_model (
  // Bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Open-drain drive, 1 releases
  output logic o_scl,
  output logic o_sda,
  // Acknowledge seen in the last slot
  output logic o_ack
);
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
    o_ack = 1'h0;
  end
  // One clock pulse of 80 ns, waiting out a stretch
  task automatic pulse(input logic b);
    o_scl = 1'h0;
    #20 o_sda = b;
    #20 o_scl = 1'h1;
    for (int k = 0; k < 600 && !i_scl; k++) #4;
    o_ack = !i_sda;
    #40;
  endtask
  // Start, address with direction, acknowledge slot, stop
  task automatic send(input logic [7:0] b);
    o_sda = 1'h0;
    #40;
    for (int i = 7; i >= 0; i--) pulse(b[i]);
    pulse(1'h1);
    o_scl = 1'h0;
    #20 o_sda = 1'h0;
    #20 o_scl = 1'h1;
    #40 o_sda = 1'h1;
    #40;
  endtask
endmodule
`default_nettype wire

//--- two_wire_slave_event_irq.sv
// Two-wire slave: command detection, event flags, shortcuts and interrupt
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Write command addressed here sets write flag
// - Read command addressed here sets read flag
// - Shortcut A: write event triggers suspend
// - Shortcut B: read event triggers suspend
// - Shortcuts reset zero, software read-write
// - Enable bits for stopped and error events
// - Enable bits for receive and transmit begun
// - Enable bits for write/read commands, reset zero
// - Receive sequence start raises receive-begun flag
// - Transmit sequence start raises transmit-begun flag
module two_wire_slave_event_irq
  import two_wire_slave_pkg::*;
#(
  parameter logic [DEV_ADDR_W-1:0] DEFAULT_DEV_ADDR = 7'h2a
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Two-wire pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  // Interrupt
  output logic o_irq
);
  localparam logic [ADDR_W-1:0] EV_OFS [NUM_EV] = '{
    OFS_EV_STOPPED, OFS_EV_ERROR, OFS_EV_RX_BEGUN,
    OFS_EV_TX_BEGUN, OFS_EV_WRITE_CMD, OFS_EV_READ_CMD
  };

  function automatic logic [NUM_EV-1:0] enable_mask(input logic [DATA_W-1:0] word);
    enable_mask = {word[IE_READ_CMD], word[IE_WRITE_CMD], word[IE_TX_BEGUN],
                   word[IE_RX_BEGUN], word[IE_ERROR], word[IE_STOPPED]};
  endfunction

  link_state_t state_q;
  link_state_t state_d;
  logic [NUM_EV-1:0] ev_q;
  logic [NUM_EV-1:0] ev_d;
  logic [NUM_EV-1:0] ev_set;
  logic [1:0] sc_q;
  logic [DATA_W-1:0] ie_q;
  logic en_q;
  logic [DEV_ADDR_W-1:0] dev_addr_q;
  logic susp_q;
  logic susp_d;
  logic scl_hold_q;
  logic scl_oe_n_q;
  logic sda_oe_n_q;
  logic sda_drive_q;
  logic sda_drive_d;
  logic addressed_q;
  logic addressed_d;
  logic master_nack_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic irq_q;
  logic [DATA_W-1:0] rdata_q;
  logic scl_s;
  logic sda_s;
  logic [7:0] shift_byte;
  logic [3:0] shift_count;
  logic shift_clear;

  pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_scl),
    .o_level(scl_s)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_sda),
    .o_level(sda_s)
  );

  // Line conditions seen on the synchronised levels
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire byte_done = scl_fall & (shift_count == BYTE_BITS);
  wire mid_byte = (state_q == ST_ADDR || state_q == ST_RX || state_q == ST_TX)
                  && (shift_count != 4'h0);
  wire addr_match = (shift_byte[7:1] == dev_addr_q);
  wire cmd_read = shift_byte[0];
  wire data_phase = (state_q == ST_RX) || (state_q == ST_TX);

  bit_shifter u_shifter (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_clear(shift_clear),
    .i_shift(scl_rise & (state_q == ST_ADDR || data_phase)),
    .i_bit(sda_s),
    .o_byte(shift_byte),
    .o_count(shift_count)
  );

  // Register decode
  wire [NUM_EV-1:0] ev_sel;
  for (genvar g = 0; g < NUM_EV; g++) begin : g_ev_sel
    assign ev_sel[g] = (i_addr == EV_OFS[g]);
  end
  wire sc_sel = (i_addr == OFS_SHORTCUTS);
  wire ie_sel = (i_addr == OFS_INT_ENABLE);
  wire en_sel = (i_addr == OFS_ENABLE);
  wire st_sel = (i_addr == OFS_STATUS);
  wire da_sel = (i_addr == OFS_OWN_ADDR);
  wire susp_task = i_wr & (i_addr == OFS_TASK_SUSPEND) & i_wdata[0];
  wire resume_task = i_wr & (i_addr == OFS_TASK_RESUME) & i_wdata[0];
  wire [NUM_EV-1:0] ev_clr = ({NUM_EV{i_wr & ~i_wdata[0]}} | {NUM_EV{i_rd}}) & ev_sel;
  wire [NUM_EV-1:0] ie_mask = enable_mask(ie_q);
  wire [DATA_W-1:0] ev_word = {31'h0, |(ev_sel & ev_q)};
  wire [DATA_W-1:0] sc_word = {30'h0, sc_q};
  wire [DATA_W-1:0] en_word = {31'h0, en_q};
  wire [DATA_W-1:0] st_word = {30'h0, addressed_q, susp_q};
  wire [DATA_W-1:0] da_word = {25'h0, dev_addr_q};
  wire [DATA_W-1:0] rdata_d = (|ev_sel) ? ev_word :
                              sc_sel ? sc_word :
                              ie_sel ? ie_q :
                              en_sel ? en_word :
                              st_sel ? st_word :
                              da_sel ? da_word : RESET_WORD;

  // Shortcut links from command events to the suspend task
  wire short_suspend = (ev_set[EV_WRITE_CMD] & sc_q[SC_WRITE_SUSPEND])
                       | (ev_set[EV_READ_CMD] & sc_q[SC_READ_SUSPEND]);

  // Link state machine
  always_comb begin
    state_d = state_q;
    ev_set = '0;
    sda_drive_d = sda_drive_q;
    addressed_d = addressed_q;
    shift_clear = 1'b0;
    if (!en_q) begin
      state_d = ST_IDLE;
      sda_drive_d = 1'b0;
      addressed_d = 1'b0;
      shift_clear = 1'b1;
    end else if (start_cond) begin
      ev_set[EV_ERROR] = mid_byte;
      state_d = ST_ADDR;
      sda_drive_d = 1'b0;
      shift_clear = 1'b1;
    end else if (stop_cond) begin
      ev_set[EV_ERROR] = mid_byte;
      ev_set[EV_STOPPED] = addressed_q;
      state_d = ST_IDLE;
      sda_drive_d = 1'b0;
      addressed_d = 1'b0;
      shift_clear = 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_drive_d = 1'b0;
        end
        ST_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              state_d = ST_ADDR_ACK;
              sda_drive_d = 1'b1;
              addressed_d = 1'b1;
              ev_set[EV_WRITE_CMD] = ~cmd_read;
              ev_set[EV_READ_CMD] = cmd_read;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_drive_d = 1'b0;
            shift_clear = 1'b1;
            state_d = cmd_read ? ST_TX : ST_RX;
            ev_set[EV_TX_BEGUN] = cmd_read;
            ev_set[EV_RX_BEGUN] = ~cmd_read;
          end
        end
        ST_RX: begin
          if (byte_done) begin
            state_d = ST_RX_ACK;
            sda_drive_d = 1'b1;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            state_d = ST_RX;
            sda_drive_d = 1'b0;
            shift_clear = 1'b1;
          end
        end
        ST_TX: begin
          if (byte_done) begin
            state_d = ST_TX_ACK;
          end
        end
        ST_TX_ACK: begin
          if (scl_fall) begin
            state_d = master_nack_q ? ST_IDLE : ST_TX;
            shift_clear = 1'b1;
          end
        end
        default: begin
          state_d = ST_IDLE;
          sda_drive_d = 1'b0;
        end
      endcase
    end
  end

  // Hardware set wins over a clear in the same cycle
  assign ev_d = (ev_q & ~ev_clr) | ev_set;
  assign susp_d = (susp_q & ~resume_task & en_q) | susp_task | short_suspend;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      ev_q <= '0;
      addressed_q <= 1'b0;
      sda_drive_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      master_nack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ev_q <= ev_d;
      addressed_q <= addressed_d;
      sda_drive_q <= sda_drive_d;
      sda_oe_n_q <= ~sda_drive_d;
      master_nack_q <= (state_q == ST_TX_ACK && scl_rise) ? sda_s : master_nack_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sc_q <= 2'b00;
      ie_q <= RESET_WORD;
      en_q <= 1'b0;
      dev_addr_q <= DEFAULT_DEV_ADDR;
    end else if (i_wr) begin
      sc_q <= sc_sel ? i_wdata[1:0] : sc_q;
      ie_q <= ie_sel ? (i_wdata & IE_VALID) : ie_q;
      en_q <= en_sel ? i_wdata[0] : en_q;
      dev_addr_q <= da_sel ? i_wdata[DEV_ADDR_W-1:0] : dev_addr_q;
    end
  end

  // Suspend holds the clock line low once it is seen low
  wire scl_hold_d = susp_q & (scl_hold_q | ~scl_s);
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      susp_q <= 1'b0;
      scl_hold_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      susp_q <= susp_d;
      scl_hold_q <= scl_hold_d;
      scl_oe_n_q <= ~scl_hold_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_q <= 1'b0;
      rdata_q <= RESET_WORD;
    end else begin
      irq_q <= |(ev_q & ie_mask);
      rdata_q <= i_rd ? rdata_d : RESET_WORD;
    end
  end

  logic sda_out_q;
  logic scl_out_q;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sda_out_q <= 1'b0;
      scl_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
      scl_out_q <= 1'b0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_sda_out = sda_out_q;
  assign o_scl_out = scl_out_q;
  assign o_sda_oe_n = sda_oe_n_q;
  assign o_scl_oe_n = scl_oe_n_q;
endmodule
`default_nettype wire

//--- two_wire_slave_event_irq_props.sv
// Port-level checker for the two-wire slave event block
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_event_irq_props
  import two_wire_slave_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // Pins and interrupt
  input wire logic i_scl,
  input wire logic o_scl_out,
  input wire logic o_scl_oe_n,
  input wire logic o_irq
);
  logic [1:0] sc_q;
  logic [DATA_W-1:0] ie_q;
  logic armed_q;
  wire logic wr_sc = i_wr && i_addr == OFS_SHORTCUTS;
  wire logic wr_ie = i_wr && i_addr == OFS_INT_ENABLE;
  wire logic rd_sc = i_rd && i_addr == OFS_SHORTCUTS;
  wire logic rd_ie = i_rd && i_addr == OFS_INT_ENABLE;
  wire logic wr_susp = i_wr && i_addr == OFS_TASK_SUSPEND && i_wdata[0];
  wire logic wr_resume = i_wr && i_addr == OFS_TASK_RESUME && i_wdata[0];

  // Shadows of the shortcut and enable registers, and any stretch source since resume
  always_ff @(posedge i_clk) begin
    sc_q <= i_reset ? 2'h0 : (wr_sc ? i_wdata[1:0] : sc_q);
    ie_q <= i_reset ? 32'h0 : (wr_ie ? (i_wdata & IE_VALID) : ie_q);
    armed_q <= i_reset ? 1'b0 : (wr_susp | (sc_q != 2'h0) | (armed_q & ~wr_resume));
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_EV_BIT0: assert property (i_rd && (i_addr == OFS_EV_WRITE_CMD ||
    i_addr == OFS_EV_READ_CMD) |=> o_rdata[31:1] == 31'h0)
    else $error("event register upper bits set");
  AST_SC_RW: assert property (wr_sc ##1 rd_sc |=>
    o_rdata == {30'h0, $past(i_wdata[1:0], 2)})
    else $error("shortcut readback wrong");
  AST_IE_RW: assert property (wr_ie ##1 rd_ie |=>
    o_rdata == ($past(i_wdata, 2) & IE_VALID))
    else $error("enable readback wrong");
  AST_IRQ_GATED: assert property ((ie_q == 32'h0) [*3] |-> !o_irq)
    else $error("interrupt with all enables off");
  AST_NO_STRETCH: assert property ((!armed_q) [*8] |-> o_scl_oe_n)
    else $error("clock stretch without shortcut");
  AST_STRETCH_LOW: assert property ($fell(o_scl_oe_n) |->
    !$past(i_scl, 3) && !o_scl_out)
    else $error("stretch began while clock high");
  AST_RESUME: assert property (i_wr && i_addr == OFS_TASK_RESUME && i_wdata[0]
    |-> ##[1:3] o_scl_oe_n)
    else $error("stretch not released by resume");

  cover property (wr_sc ##1 rd_sc);
  cover property ($fell(o_scl_oe_n));
  cover property ($rose(o_irq));
endmodule
bind two_wire_slave_event_irq two_wire_slave_event_irq_props u_props (
  .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(i_scl), .o_scl_out(o_scl_out),
  .o_scl_oe_n(o_scl_oe_n), .o_irq(o_irq));
`default_nettype wire

//--- two_wire_slave_pkg.sv
// Constants, register map and state codes for the two-wire slave event block
package two_wire_slave_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_EV = 6;

  localparam logic [ADDR_W-1:0] OFS_TASK_SUSPEND = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_TASK_RESUME = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_EV_STOPPED = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_EV_ERROR = 12'h124;
  localparam logic [ADDR_W-1:0] OFS_EV_RX_BEGUN = 12'h14c;
  localparam logic [ADDR_W-1:0] OFS_EV_TX_BEGUN = 12'h150;
  localparam logic [ADDR_W-1:0] OFS_EV_WRITE_CMD = 12'h164;
  localparam logic [ADDR_W-1:0] OFS_EV_READ_CMD = 12'h168;
  localparam logic [ADDR_W-1:0] OFS_SHORTCUTS = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 12'h300;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h500;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h520;
  localparam logic [ADDR_W-1:0] OFS_OWN_ADDR = 12'h588;

  // Event order inside the flag vector
  localparam int unsigned EV_STOPPED = 0;
  localparam int unsigned EV_ERROR = 1;
  localparam int unsigned EV_RX_BEGUN = 2;
  localparam int unsigned EV_TX_BEGUN = 3;
  localparam int unsigned EV_WRITE_CMD = 4;
  localparam int unsigned EV_READ_CMD = 5;

  // Interrupt enable field positions
  localparam int unsigned IE_STOPPED = 1;
  localparam int unsigned IE_ERROR = 9;
  localparam int unsigned IE_RX_BEGUN = 19;
  localparam int unsigned IE_TX_BEGUN = 20;
  localparam int unsigned IE_WRITE_CMD = 25;
  localparam int unsigned IE_READ_CMD = 26;
  localparam logic [DATA_W-1:0] IE_VALID = 32'h0618_0202;

  // Shortcut field positions
  localparam int unsigned SC_WRITE_SUSPEND = 0;
  localparam int unsigned SC_READ_SUSPEND = 1;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int unsigned DEV_ADDR_W = 7;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_RX = 7'b0001000,
    ST_RX_ACK = 7'b0010000,
    ST_TX = 7'b0100000,
    ST_TX_ACK = 7'b1000000
  } link_state_t;
endpackage
